// file: sensor_cfg_pkg.sv
package sensor_cfg_pkg;
   localparam logic [7:0] PART_ID_OFFSET = 8'h3E;
   localparam logic [7:0] FILTER_CFG_OFFSET = 8'h40;
   localparam logic [7:0] OUTPUT_SEL_OFFSET = 8'h42;

   localparam logic [7:0] PART_ID_RESET = 8'h00;
   localparam logic [7:0] FILTER_CFG_RESET = 8'h00;
   localparam logic [7:0] OUTPUT_SEL_RESET = 8'h00;
   // arbitrary neutral identity value, not a real part code
   localparam logic [7:0] PART_ID_FACTORY = 8'hA5;

   localparam int LOWPASS_LSB = 4;
   localparam int SLOT0_SEL_LSB = 5;
   localparam int SLOT1_SEL_LSB = 2;

   localparam logic [3:0] LPF_370HZ_2P = 4'h0;
   localparam logic [3:0] LPF_1000HZ_4P = 4'h3;

   localparam logic [1:0] SEL_RELATIVE = 2'h0;
   localparam logic [1:0] SEL_ABSOLUTE = 2'h1;
   localparam logic [1:0] SEL_BASELINE = 2'h2;
   localparam logic [1:0] SEL_TEMPERATURE = 2'h3;
   localparam logic [15:0] PSI5_PRESSURE_SUBST = 16'h01F4;

   localparam logic [12:0] BLOCK_DEFAULT_US = 13'd450;
   localparam logic [12:0] PSI5_BLOCK_MIN = 13'd10;
   localparam int CLK_MHZ = 100;
   localparam int BLOCK_CYC_W = 20;
endpackage : sensor_cfg_pkg

// file: blocking_time_decode.sv
`timescale 1ns/1ps
module blocking_time_decode (
   input wire logic [12:0] blocking_time_field,
   input wire logic psi5_mode,
   output logic [12:0] blocking_us
);
   always_comb begin
      if (blocking_time_field == 13'h0000) begin
         blocking_us = sensor_cfg_pkg::BLOCK_DEFAULT_US;
      end else if (psi5_mode && blocking_time_field < sensor_cfg_pkg::PSI5_BLOCK_MIN) begin
         blocking_us = sensor_cfg_pkg::BLOCK_DEFAULT_US;
      end else begin
         blocking_us = blocking_time_field;
      end
   end
endmodule : blocking_time_decode

// file: slot_content_mux.sv
`timescale 1ns/1ps
module slot_content_mux (
   input wire logic [1:0] content_sel,
   input wire logic psi5_mode,
   input wire logic [15:0] relative_pressure,
   input wire logic [15:0] absolute_pressure,
   input wire logic [15:0] baseline_pressure,
   input wire logic [15:0] temperature,
   output logic [15:0] stored_value,
   output logic [15:0] tx_value
);
   always_comb begin
      case (content_sel)
         sensor_cfg_pkg::SEL_RELATIVE: stored_value = relative_pressure;
         sensor_cfg_pkg::SEL_ABSOLUTE: stored_value = absolute_pressure;
         sensor_cfg_pkg::SEL_BASELINE: stored_value = baseline_pressure;
         default: stored_value = temperature;
      endcase
      tx_value = stored_value;
      // psi5 frames are too short for the absolute scale, so a marker goes out instead
      if (psi5_mode && (content_sel == sensor_cfg_pkg::SEL_ABSOLUTE ||
                        content_sel == sensor_cfg_pkg::SEL_BASELINE)) begin
         tx_value = sensor_cfg_pkg::PSI5_PRESSURE_SUBST;
      end
   end
endmodule : slot_content_mux

// file: sensor_user_config_regs.sv
// Notes on behaviour
// - dsi3 blocking field zero means 450 us, else field times 1 us.
// - psi5 field 0..9 means 450 us, 10..8191 means field times 1 us.
// - part identifier stores 8 bits, reset zero; zero reads as factory code.
// - part identifier is readable in every operating mode.
// - config registers are written, and read except identifier, only in dsi3 or psi5 diagnostic.
// - all three registers feed the read/write array check value.
// - a changing write to filter or output select pulses dsp datapath reset.
// - filter bits 7:4 select low-pass: 370, 400, 800, 1000 Hz; others reserved.
// - output select bits 6:5 choose slot 0 content: rel, abs, filtered abs, temp.
// - output select bits 3:2 choose slot 1 content with the same mapping.
// - psi5 sends 1F4h for absolute or filtered absolute; dsi3 sends stored value.
// - slot 1 content is taken from non-interpolated samples.
`timescale 1ns/1ps
module sensor_user_config_regs (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic psi5_mode,
   input wire logic psi5_diag_mode,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [12:0] blocking_time_field,
   input wire logic [3:0][15:0] interp_samples,
   input wire logic [3:0][15:0] raw_samples,
   output logic [7:0] reg_rdata,
   output logic reg_ack,
   output logic reg_refused,
   output logic [3:0] lowpass_select,
   output logic lowpass_reserved,
   output logic dsp_reset,
   output logic [7:0] rw_array_check,
   output logic [12:0] blocking_us,
   output logic [19:0] blocking_cycles,
   output logic [15:0] sensor_result_0,
   output logic [15:0] sensor_result_1,
   output logic [15:0] tx_data_0,
   output logic [15:0] tx_data_1
);
   typedef struct packed {
      logic [7:0] part_identifier;
      logic [7:0] filter_config;
      logic [7:0] output_select_config;
      logic [7:0] rdata;
      logic ack;
      logic refused;
      logic dsp_reset;
      logic lp_rsv;
      logic [7:0] check;
      logic [12:0] blk_us;
      logic [19:0] blk_cyc;
      logic [15:0] res0;
      logic [15:0] res1;
      logic [15:0] tx0;
      logic [15:0] tx1;
   } state_t;

   state_t st_r;
   state_t st_nxt;
   logic [12:0] blk_us_dec;
   logic [1:0][15:0] slot_stored;
   logic [1:0][15:0] slot_tx;
   logic [1:0][1:0] slot_sel;
   logic cfg_access_ok;
   logic wr_id;
   logic wr_filt;
   logic wr_osel;

   assign cfg_access_ok = !psi5_mode || psi5_diag_mode;
   assign wr_id = reg_wr && cfg_access_ok && reg_addr == sensor_cfg_pkg::PART_ID_OFFSET;
   assign wr_filt = reg_wr && cfg_access_ok && reg_addr == sensor_cfg_pkg::FILTER_CFG_OFFSET;
   assign wr_osel = reg_wr && cfg_access_ok && reg_addr == sensor_cfg_pkg::OUTPUT_SEL_OFFSET;

   assign slot_sel[0] = st_r.output_select_config[sensor_cfg_pkg::SLOT0_SEL_LSB +: 2];
   assign slot_sel[1] = st_r.output_select_config[sensor_cfg_pkg::SLOT1_SEL_LSB +: 2];

   blocking_time_decode u_blk (
      .blocking_time_field(blocking_time_field),
      .psi5_mode(psi5_mode),
      .blocking_us(blk_us_dec)
   );

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_slot
         // slot 1 bypasses the interpolator so its samples keep their own timing
         slot_content_mux u_mux (
            .content_sel(slot_sel[gi]),
            .psi5_mode(psi5_mode),
            .relative_pressure(gi == 0 ? interp_samples[0] : raw_samples[0]),
            .absolute_pressure(gi == 0 ? interp_samples[1] : raw_samples[1]),
            .baseline_pressure(gi == 0 ? interp_samples[2] : raw_samples[2]),
            .temperature(gi == 0 ? interp_samples[3] : raw_samples[3]),
            .stored_value(slot_stored[gi]),
            .tx_value(slot_tx[gi])
         );
      end
   endgenerate

   localparam int BLOCK_CYC_W = sensor_cfg_pkg::BLOCK_CYC_W;

   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = 1'b0;
      st_nxt.refused = 1'b0;
      st_nxt.dsp_reset = 1'b0;
      if (wr_id) begin
         st_nxt.part_identifier = reg_wdata;
      end
      if (wr_filt) begin
         st_nxt.filter_config = reg_wdata;
         st_nxt.dsp_reset = reg_wdata != st_r.filter_config;
      end
      if (wr_osel) begin
         st_nxt.output_select_config = reg_wdata;
         if (reg_wdata != st_r.output_select_config) begin
            st_nxt.dsp_reset = 1'b1;
         end
      end
      if (reg_wr) begin
         st_nxt.ack = 1'b1;
         // locked mode and unmapped addresses both count as a refused write
         st_nxt.refused = !(wr_id || wr_filt || wr_osel);
      end
      if (reg_rd) begin
         st_nxt.ack = 1'b1;
         st_nxt.rdata = 8'h00;
         case (reg_addr)
            sensor_cfg_pkg::PART_ID_OFFSET: begin
               // identifier answers in every mode
               st_nxt.rdata = (st_r.part_identifier == 8'h00) ?
                  sensor_cfg_pkg::PART_ID_FACTORY : st_r.part_identifier;
            end
            sensor_cfg_pkg::FILTER_CFG_OFFSET: begin
               if (cfg_access_ok) begin
                  st_nxt.rdata = st_r.filter_config;
               end else begin
                  st_nxt.refused = 1'b1;
               end
            end
            sensor_cfg_pkg::OUTPUT_SEL_OFFSET: begin
               if (cfg_access_ok) begin
                  st_nxt.rdata = st_r.output_select_config;
               end else begin
                  st_nxt.refused = 1'b1;
               end
            end
            default: st_nxt.refused = 1'b1;
         endcase
      end
      // check value covers the stored words, not the substituted read value
      st_nxt.check = st_nxt.part_identifier ^ st_nxt.filter_config ^
                     st_nxt.output_select_config;
      st_nxt.lp_rsv = st_nxt.filter_config[sensor_cfg_pkg::LOWPASS_LSB +: 4] >
                      sensor_cfg_pkg::LPF_1000HZ_4P;
      st_nxt.blk_us = blk_us_dec;
      st_nxt.blk_cyc = BLOCK_CYC_W'(blk_us_dec) * BLOCK_CYC_W'(sensor_cfg_pkg::CLK_MHZ);
      st_nxt.res0 = slot_stored[0];
      st_nxt.res1 = slot_stored[1];
      st_nxt.tx0 = slot_tx[0];
      st_nxt.tx1 = slot_tx[1];
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_r <= '0;
         st_r.part_identifier <= sensor_cfg_pkg::PART_ID_RESET;
         st_r.filter_config <= sensor_cfg_pkg::FILTER_CFG_RESET;
         st_r.output_select_config <= sensor_cfg_pkg::OUTPUT_SEL_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata = st_r.rdata;
   assign reg_ack = st_r.ack;
   assign reg_refused = st_r.refused;
   assign lowpass_select = st_r.filter_config[sensor_cfg_pkg::LOWPASS_LSB +: 4];
   // codes above the 1000 Hz entry are reserved; the dsp keeps the raw code
   assign lowpass_reserved = st_r.lp_rsv;
   assign dsp_reset = st_r.dsp_reset;
   assign rw_array_check = st_r.check;
   assign blocking_us = st_r.blk_us;
   assign blocking_cycles = st_r.blk_cyc;
   assign sensor_result_0 = st_r.res0;
   assign sensor_result_1 = st_r.res1;
   assign tx_data_0 = st_r.tx0;
   assign tx_data_1 = st_r.tx1;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   a_id_zero_subst: assert property (
      reg_rd && reg_addr == sensor_cfg_pkg::PART_ID_OFFSET && st_r.part_identifier == 8'h00
      |=> reg_rdata == sensor_cfg_pkg::PART_ID_FACTORY)
      else $error("zero identifier not substituted");
   a_id_nonzero_read: assert property (
      reg_rd && reg_addr == sensor_cfg_pkg::PART_ID_OFFSET && st_r.part_identifier != 8'h00
      |=> reg_rdata == $past(st_r.part_identifier))
      else $error("stored identifier not returned");
   a_id_any_mode: assert property (
      reg_rd && reg_addr == sensor_cfg_pkg::PART_ID_OFFSET |=> reg_ack && !reg_refused)
      else $error("identifier read refused");
   a_id_write_store: assert property (
      wr_id |=> st_r.part_identifier == $past(reg_wdata))
      else $error("identifier write not stored");
   a_id_hold: assert property (
      !wr_id |=> $stable(st_r.part_identifier))
      else $error("identifier changed without a write");
   a_ack_after_req: assert property (
      reg_wr || reg_rd |=> reg_ack)
      else $error("request not acknowledged");
   a_ack_has_cause: assert property (
      reg_ack |-> $past(reg_wr || reg_rd))
      else $error("acknowledge without a request");
   a_refused_with_ack: assert property (
      reg_refused |-> reg_ack)
      else $error("refusal outside an acknowledge");
   a_write_locked: assert property (
      reg_wr && psi5_mode && !psi5_diag_mode && !reg_rd |=> reg_refused &&
      $stable(st_r.filter_config) && $stable(st_r.output_select_config) &&
      $stable(st_r.part_identifier))
      else $error("write accepted in locked mode");
   a_unmapped_write: assert property (
      reg_wr && !reg_rd && !wr_id && !wr_filt && !wr_osel |=> reg_refused)
      else $error("unmapped write not refused");
   a_high_addr_read: assert property (
      reg_rd && !reg_wr && reg_addr > sensor_cfg_pkg::OUTPUT_SEL_OFFSET
      |=> reg_refused && reg_rdata == 8'h00)
      else $error("unmapped read not refused");
   a_filt_rd_locked: assert property (
      reg_rd && !cfg_access_ok && reg_addr == sensor_cfg_pkg::FILTER_CFG_OFFSET
      |=> reg_refused && reg_rdata == 8'h00)
      else $error("locked filter read not refused");
   a_osel_rd_locked: assert property (
      reg_rd && !cfg_access_ok && reg_addr == sensor_cfg_pkg::OUTPUT_SEL_OFFSET
      |=> reg_refused && reg_rdata == 8'h00)
      else $error("locked output select read not refused");
   a_filt_rd_open: assert property (
      reg_rd && !reg_wr && cfg_access_ok && reg_addr == sensor_cfg_pkg::FILTER_CFG_OFFSET
      |=> !reg_refused && reg_rdata == $past(st_r.filter_config))
      else $error("filter read wrong");
   a_osel_rd_open: assert property (
      reg_rd && !reg_wr && cfg_access_ok && reg_addr == sensor_cfg_pkg::OUTPUT_SEL_OFFSET
      |=> !reg_refused && reg_rdata == $past(st_r.output_select_config))
      else $error("output select read wrong");
   a_filt_store: assert property (
      wr_filt |=> st_r.filter_config == $past(reg_wdata))
      else $error("filter write not stored");
   a_osel_store: assert property (
      wr_osel |=> st_r.output_select_config == $past(reg_wdata))
      else $error("output select write not stored");
   a_filt_hold: assert property (
      !wr_filt |=> $stable(st_r.filter_config))
      else $error("filter changed without a write");
   a_osel_hold: assert property (
      !wr_osel |=> $stable(st_r.output_select_config))
      else $error("output select changed without a write");
   a_check_tracks: assert property (
      rw_array_check == (st_r.part_identifier ^ st_r.filter_config ^
      st_r.output_select_config))
      else $error("array check out of step");
   a_dsp_rst_change: assert property (
      wr_filt && reg_wdata != st_r.filter_config
      |=> dsp_reset ##1 (!dsp_reset || $past(wr_filt) || $past(wr_osel)))
      else $error("filter change did not reset dsp");
   a_dsp_rst_osel: assert property (
      wr_osel && reg_wdata != st_r.output_select_config |=> dsp_reset)
      else $error("output select change did not reset dsp");
   a_dsp_rst_quiet: assert property (
      !wr_filt && !wr_osel |=> !dsp_reset)
      else $error("dsp reset without a config write");
   a_dsp_rst_cause: assert property (
      dsp_reset |-> $changed(st_r.filter_config) ||
      $changed(st_r.output_select_config))
      else $error("dsp reset without a change");
   a_lp_from_write: assert property (
      wr_filt |=> lowpass_select == $past(reg_wdata[sensor_cfg_pkg::LOWPASS_LSB +: 4]))
      else $error("lowpass select not taken from the write");
   a_lp_reserved_flag: assert property (
      lowpass_reserved == (lowpass_select > sensor_cfg_pkg::LPF_1000HZ_4P))
      else $error("reserved lowpass flag wrong");
   a_slot0_rel: assert property (
      slot_sel[0] == sensor_cfg_pkg::SEL_RELATIVE
      |=> sensor_result_0 == $past(interp_samples[0]))
      else $error("slot 0 relative wrong");
   a_slot0_temp: assert property (
      slot_sel[0] == sensor_cfg_pkg::SEL_TEMPERATURE
      |=> sensor_result_0 == $past(interp_samples[3]))
      else $error("slot 0 temperature wrong");
   a_slot1_raw: assert property (
      slot_sel[1] == sensor_cfg_pkg::SEL_RELATIVE
      |=> sensor_result_1 == $past(raw_samples[0]))
      else $error("slot 1 not from raw samples");
   a_slot1_temp: assert property (
      slot_sel[1] == sensor_cfg_pkg::SEL_TEMPERATURE
      |=> sensor_result_1 == $past(raw_samples[3]))
      else $error("slot 1 temperature wrong");
   a_psi5_subst: assert property (
      psi5_mode && slot_sel[0] == sensor_cfg_pkg::SEL_ABSOLUTE
      |=> tx_data_0 == sensor_cfg_pkg::PSI5_PRESSURE_SUBST)
      else $error("psi5 absolute not substituted");
   a_psi5_slot1_subst: assert property (
      psi5_mode && slot_sel[1] == sensor_cfg_pkg::SEL_BASELINE
      |=> tx_data_1 == sensor_cfg_pkg::PSI5_PRESSURE_SUBST)
      else $error("psi5 filtered absolute not substituted");
   a_psi5_temp_pass: assert property (
      psi5_mode && slot_sel[0] == sensor_cfg_pkg::SEL_TEMPERATURE
      |=> tx_data_0 == sensor_result_0)
      else $error("psi5 temperature altered");
   a_dsi3_as_stored: assert property (
      !psi5_mode
      |=> tx_data_0 == sensor_result_0 && tx_data_1 == sensor_result_1)
      else $error("dsi3 transmit differs from stored");
   a_dsi3_blk: assert property (
      !psi5_mode && blocking_time_field != 13'h0000
      |=> blocking_us == $past(blocking_time_field))
      else $error("dsi3 blocking time wrong");
   a_dsi3_zero_blk: assert property (
      !psi5_mode && blocking_time_field == 13'h0000
      |=> blocking_us == sensor_cfg_pkg::BLOCK_DEFAULT_US)
      else $error("dsi3 zero blocking not defaulted");
   a_psi5_short_blk: assert property (
      psi5_mode && blocking_time_field < sensor_cfg_pkg::PSI5_BLOCK_MIN
      |=> blocking_us == sensor_cfg_pkg::BLOCK_DEFAULT_US && blocking_cycles == 20'hAFC8)
      else $error("short psi5 blocking not defaulted");
   a_psi5_long_blk: assert property (
      psi5_mode && blocking_time_field >= sensor_cfg_pkg::PSI5_BLOCK_MIN
      |=> blocking_us == $past(blocking_time_field))
      else $error("psi5 blocking time wrong");
endmodule : sensor_user_config_regs

// file: bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
   input wire logic core_clk,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic reg_refused,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // one-cycle strobe; the answer is taken at the next falling edge, after the ack edge
   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
         output logic ack, output logic refused, output logic [7:0] rdata);
      @(negedge core_clk);
      reg_wr = wr;
      reg_rd = !wr;
      reg_addr = addr;
      reg_wdata = wdata;
      @(negedge core_clk);
      ack = reg_ack;
      refused = reg_refused;
      rdata = reg_rdata;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      // released lines must not look like a held request
      reg_addr = ~addr;
      reg_wdata = ~wdata;
   endtask : access
endmodule : bus_master_model

// file: sensor_user_config_regs_bench.sv
`timescale 1ns/1ps
module sensor_user_config_regs_bench;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic psi5_mode = 1'b0;
   logic psi5_diag_mode = 1'b1;
   logic [12:0] blocking_time_field = 13'h0000;
   logic [3:0][15:0] interp_samples = '0;
   logic [3:0][15:0] raw_samples = '0;
   logic reg_wr, reg_rd, reg_ack, reg_refused, lowpass_reserved, dsp_reset;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rw_array_check;
   logic [3:0] lowpass_select;
   logic [12:0] blocking_us;
   logic [19:0] blocking_cycles;
   logic [15:0] sensor_result_0, sensor_result_1, tx_data_0, tx_data_1;
   int num_errors = 0;
   int check_count = 0;
   int id_m = 0;
   int flt_m = 0;
   int sel_m = 0;
   logic [31:0] rng = 32'h4AB0;
   logic [15:0] rnd_v;
   int fields[8] = '{0, 1, 9, 10, 11, 450, 8190, 8191};

   always #5 core_clk = ~core_clk;

   sensor_user_config_regs uut (.core_clk(core_clk), .srst(srst), .psi5_mode(psi5_mode),
      .psi5_diag_mode(psi5_diag_mode), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .blocking_time_field(blocking_time_field),
      .interp_samples(interp_samples), .raw_samples(raw_samples), .reg_rdata(reg_rdata),
      .reg_ack(reg_ack), .reg_refused(reg_refused), .lowpass_select(lowpass_select),
      .lowpass_reserved(lowpass_reserved), .dsp_reset(dsp_reset),
      .rw_array_check(rw_array_check), .blocking_us(blocking_us),
      .blocking_cycles(blocking_cycles), .sensor_result_0(sensor_result_0),
      .sensor_result_1(sensor_result_1), .tx_data_0(tx_data_0), .tx_data_1(tx_data_1));

   bus_master_model bfm (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .reg_refused(reg_refused), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata));

   function automatic logic [15:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng[15:0];
   endfunction : rnd

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask : chk

   task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      logic ack, refd;
      logic [7:0] rd;
      int old, exp_rd;
      bit refuse;
      old = flt_m * 256 + sel_m;
      refuse = !(a == 8'h3E || a == 8'h40 || a == 8'h42);
      refuse = refuse || (psi5_mode && !psi5_diag_mode && (wr || a != 8'h3E));
      exp_rd = 0;
      bfm.access(wr, a, d, ack, refd, rd);
      if (wr && !refuse) begin
         if (a == 8'h3E) id_m = d;
         else if (a == 8'h40) flt_m = d;
         else sel_m = d;
      end
      if (!wr && !refuse) begin
         if (a == 8'h3E) exp_rd = (id_m == 0) ? sensor_cfg_pkg::PART_ID_FACTORY : id_m;
         else exp_rd = (a == 8'h40) ? flt_m : sel_m;
      end
      chk(ack, 1, "ack");
      chk(refd, refuse, "refused");
      if (!wr) chk(rd, exp_rd, "read data");
      chk(dsp_reset, wr && (flt_m * 256 + sel_m != old), "dsp reset");
      chk(lowpass_select, flt_m >> 4, "lowpass");
      chk(lowpass_reserved, (flt_m >> 4) > 3, "lowpass reserved");
      chk(rw_array_check, id_m ^ flt_m ^ sel_m, "array check");
   endtask : acc

   task automatic dp_chk(input int f);
      int s0, s1, us;
      s0 = (sel_m >> 5) & 3;
      s1 = (sel_m >> 2) & 3;
      us = (f == 0 || (psi5_mode && f < 10)) ? 450 : f;
      for (int i = 0; i < 4; i++) begin
         interp_samples[i] = rnd();
         raw_samples[i] = rnd();
      end
      blocking_time_field = f[12:0];
      @(negedge core_clk);
      chk(sensor_result_0, interp_samples[s0], "slot 0");
      chk(sensor_result_1, raw_samples[s1], "slot 1");
      chk(tx_data_0, (psi5_mode && (s0 == 1 || s0 == 2)) ? 16'h01F4 : interp_samples[s0],
         "tx 0");
      chk(tx_data_1, (psi5_mode && (s1 == 1 || s1 == 2)) ? 16'h01F4 : raw_samples[s1],
         "tx 1");
      chk(blocking_us, us, "blocking us");
      chk(blocking_cycles, us * 100, "blocking cycles");
   endtask : dp_chk

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim

   initial begin
      repeat (100000) @(posedge core_clk);
      num_errors++;
      end_sim();
   end

   initial begin
      repeat (5) @(negedge core_clk);
      srst = 1'b0;
      acc(0, 8'h3E, 8'h00);
      acc(0, 8'h40, 8'h00);
      acc(0, 8'h42, 8'h00);
      acc(0, 8'h44, 8'h00);
      rnd_v = rnd();
      acc(1, 8'h41, rnd_v[7:0]);
      for (int c = 0; c < 16; c++) begin
         rnd_v = rnd();
         acc(1, 8'h40, {c[3:0], rnd_v[3:0]});
         acc(0, 8'h40, 8'h00);
      end
      acc(1, 8'h40, flt_m[7:0]);
      for (int m = 0; m < 2; m++) begin
         psi5_mode = m[0];
         for (int c = 0; c < 16; c++) begin
            rnd_v = rnd();
            acc(1, 8'h42, {rnd_v[0], c[3:2], rnd_v[1], c[1:0], rnd_v[3:2]});
            // datapath settles one cycle after the config change
            // blocking values include zero and the psi5 below-minimum fields 1 and 9
            dp_chk(fields[c % 8]);
         end
      end
      acc(1, 8'h3E, 8'h5C);
      acc(0, 8'h3E, 8'h00);
      acc(1, 8'h3E, 8'h00);
      acc(0, 8'h3E, 8'h00);
      psi5_diag_mode = 1'b0;
      acc(1, 8'h3E, 8'h77);
      acc(0, 8'h3E, 8'h00);
      acc(1, 8'h40, 8'h30);
      acc(0, 8'h40, 8'h00);
      acc(1, 8'h42, 8'h00);
      acc(0, 8'h42, 8'h00);
      dp_chk(5);
      srst = 1'b1;
      repeat (2) @(negedge core_clk);
      srst = 1'b0;
      id_m = 0;
      flt_m = 0;
      sel_m = 0;
      psi5_mode = 1'b0;
      acc(0, 8'h3E, 8'h00);
      acc(0, 8'h42, 8'h00);
      end_sim();
   end
endmodule : sensor_user_config_regs_bench
